//--- core/dpd_pkg.sv
package dpd_pkg;
  // Command encodings seen on the command bus
  typedef enum logic [2:0] {
    DPD_CMD_DES = 3'h0,
    DPD_CMD_NOP = 3'h1,
    DPD_CMD_ACT = 3'h2,
    DPD_CMD_PRE = 3'h3,
    DPD_CMD_REF = 3'h4,
    DPD_CMD_RD  = 3'h5,
    DPD_CMD_WR  = 3'h6,
    DPD_CMD_MRS = 3'h7
  } dpd_cmd_t;

  // Device power state
  typedef enum logic [2:0] {
    DPD_ST_RESET  = 3'h0,
    DPD_ST_IDLE   = 3'h1,
    DPD_ST_PDWAIT = 3'h2,
    DPD_ST_PPD    = 3'h3,
    DPD_ST_APD    = 3'h4,
    DPD_ST_SREF   = 3'h5,
    DPD_ST_MPX    = 3'h6
  } dpd_state_t;

  // Default timing counts in link clock cycles
  localparam int unsigned TCKE_CYC    = 4;
  localparam int unsigned TCPDED_CYC  = 4;
  localparam int unsigned TXP_CYC     = 6;
  localparam int unsigned TMPX_LH_CYC = 8;
  localparam int unsigned WL_CYC      = 9;
  localparam int unsigned TDODTL_CYC  = 8;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned PARK_W      = 3;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  // Link clock divider half-period in system clocks
  localparam int unsigned CK_HALF     = 6;
endpackage

//--- core/dpd_link_if.sv
interface dpd_link_if;
  logic               ck;
  logic               reset_n;
  logic               cke;
  dpd_pkg::dpd_cmd_t  cmd;
  logic               odt;
  logic               odt_valid;
  logic               cmd_rx_en;
  logic               odt_buf_en;
  logic               park_on;
  logic               nom_on;

  modport dev (
    input  ck, reset_n, cke, cmd, odt, odt_valid,
    output cmd_rx_en, odt_buf_en, park_on, nom_on
  );
  modport ctl (
    output ck, reset_n, cke, cmd, odt, odt_valid,
    input  cmd_rx_en, odt_buf_en, park_on, nom_on
  );
endinterface

//--- core/dpd_device.sv
// Notes on behaviour
// RL1 - Enter power-down on CKE low with DESELECT
// RL2 - Controller keeps CKE high during busy operations; controller drops CKE on request, device waits in PDWAIT
// RL3 - Finish row, precharge, refresh before power-down
// RL4 - Closed banks precharge, open banks active
// RL5 - Controller resets DLL if unlocked at entry; dpd_ctrl has no DLL reset
// RL6 - Buffers off except clock, CKE, reset
// RL7 - ODT buffer off only when disable bit set
// RL8 - Park termination kept during power-down
// RL9 - Receivers off only after tCPDED
// RL10 - DLL kept on; controller keeps clock
// RL11 - Reset low exits power-down immediately
// RL12 - Controller holds CKE level for tCKE
// RL13 - Controller limits power-down to nine tREFI
// RL14 - Exit on CKE high with DESELECT; tXP
// RL15 - Controller gives valid ODT at exit
// RL16 - Controller waits tPD before exit
// RL17 - Controller holds ODT steady around entry
// RL18 - ODT floats after tCPDED; tANPD ambiguity
// RL19 - NOP exit only without parity, CAL, gear-down
// RL20 - Only NOP inside tMPX_LH after exit
// RL21 - Intervals are programmable cycle counters; controller tCKE, tXP and tMPX_LH counts are fixed
module dpd_device #(
  parameter int unsigned BANKS = 16
) (
  // System clock domain
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Link side
  dpd_link_if.dev                            lnk,
  // Configuration, system domain
  input  wire logic                          odt_buf_dis,
  input  wire logic [dpd_pkg::PARK_W-1:0]    park_sel,
  input  wire logic                          nom_en,
  input  wire logic                          mpx_ok_cfg,
  input  wire logic [dpd_pkg::CNT_W-1:0]     tcpded_cfg,
  input  wire logic [dpd_pkg::CNT_W-1:0]     tmpx_cfg,
  // Core status, system domain
  input  wire logic [BANKS-1:0]              bank_open,
  input  wire logic                          core_busy,
  input  wire logic                          sref_req,
  // Status, system domain
  output logic [2:0]                         pd_state,
  output logic                               dll_on,
  output logic                               in_pd
);
  dpd_pkg::dpd_state_t st_q;
  logic [dpd_pkg::CNT_W-1:0] cnt_q;
  logic                      cke_q;
  logic                      des_q;
  // Two-flop crossings of system-domain config and core status into link domain
  logic [3+dpd_pkg::PARK_W:0] cfg_s1_q, cfg_s2_q;
  logic [2*dpd_pkg::CNT_W-1:0] tcfg_s1_q, tcfg_s2_q;
  logic [1:0] stat_s1_q, stat_s2_q;
  logic [BANKS-1:0] bank_s1_q, bank_s2_q;
  logic       any_open;
  logic       pd_now;
  logic       odt_dis, nom_cfg, mpx_ok;
  logic [dpd_pkg::PARK_W-1:0] park_cfg;
  logic [dpd_pkg::CNT_W-1:0] tcpded, tmpx;

  // Link-side synchronisers
  always_ff @(posedge lnk.ck) begin
    cfg_s1_q  <= {odt_buf_dis, nom_en, mpx_ok_cfg, 1'b0, park_sel};
    cfg_s2_q  <= cfg_s1_q;
    tcfg_s1_q <= {tcpded_cfg, tmpx_cfg};
    tcfg_s2_q <= tcfg_s1_q;
    stat_s1_q <= {core_busy, sref_req};
    stat_s2_q <= stat_s1_q;
    bank_s1_q <= bank_open;
    bank_s2_q <= bank_s1_q;
  end

  assign odt_dis  = cfg_s2_q[3+dpd_pkg::PARK_W];
  assign nom_cfg  = cfg_s2_q[2+dpd_pkg::PARK_W];
  assign mpx_ok   = cfg_s2_q[1+dpd_pkg::PARK_W];
  assign park_cfg = cfg_s2_q[dpd_pkg::PARK_W-1:0];
  assign tcpded   = tcfg_s2_q[2*dpd_pkg::CNT_W-1:dpd_pkg::CNT_W];
  assign tmpx     = tcfg_s2_q[dpd_pkg::CNT_W-1:0];
  assign any_open = |bank_s2_q;

  // Either power-down state, input buffers may be parked
  assign pd_now   = (st_q == dpd_pkg::DPD_ST_PPD) || (st_q == dpd_pkg::DPD_ST_APD);

  // Registered command sample
  always_ff @(posedge lnk.ck) begin
    cke_q <= lnk.cke;
    des_q <= (lnk.cmd == dpd_pkg::DPD_CMD_DES);
  end

  // Power state machine
  always_ff @(posedge lnk.ck) begin
    if (!lnk.reset_n) begin // RL11
      st_q  <= dpd_pkg::DPD_ST_RESET;
      cnt_q <= dpd_pkg::CNT_ZERO;
    end else begin
      if (cnt_q != dpd_pkg::CNT_ZERO) cnt_q <= cnt_q - dpd_pkg::CNT_ONE; // RL21
      case (st_q)
        dpd_pkg::DPD_ST_RESET: st_q <= dpd_pkg::DPD_ST_IDLE;
        dpd_pkg::DPD_ST_IDLE: begin
          // Self refresh request wins, the bus carries deselect either way
          if (!lnk.cke && cke_q && stat_s2_q[0]) begin // RL19
            st_q <= dpd_pkg::DPD_ST_SREF;
          end else if (!lnk.cke && cke_q && des_q) begin // RL1
            st_q  <= dpd_pkg::DPD_ST_PDWAIT;
            cnt_q <= tcpded; // RL9
          end
        end
        dpd_pkg::DPD_ST_PDWAIT: begin
          if (lnk.cke && des_q) begin // RL14
            st_q <= dpd_pkg::DPD_ST_IDLE;
          end else if (cnt_q == dpd_pkg::CNT_ZERO && !stat_s2_q[1]) begin // RL3
            st_q <= any_open ? dpd_pkg::DPD_ST_APD : dpd_pkg::DPD_ST_PPD; // RL4
          end
        end
        dpd_pkg::DPD_ST_PPD, dpd_pkg::DPD_ST_APD: begin
          if (lnk.cke && des_q) st_q <= dpd_pkg::DPD_ST_IDLE; // RL14
        end
        dpd_pkg::DPD_ST_SREF: begin
          if (lnk.cke) begin
            if (mpx_ok) begin // RL19
              st_q  <= dpd_pkg::DPD_ST_MPX;
              cnt_q <= tmpx; // RL20
            end else begin
              st_q <= dpd_pkg::DPD_ST_IDLE;
            end
          end
        end
        dpd_pkg::DPD_ST_MPX: begin
          if (cnt_q == dpd_pkg::CNT_ZERO) st_q <= dpd_pkg::DPD_ST_IDLE;
        end
        default: st_q <= dpd_pkg::DPD_ST_RESET;
      endcase
    end
  end

  // Receiver and termination controls
  always_ff @(posedge lnk.ck) begin
    if (!lnk.reset_n) begin
      lnk.cmd_rx_en  <= 1'b1;
      lnk.odt_buf_en <= 1'b1;
      lnk.park_on    <= 1'b0;
      lnk.nom_on     <= 1'b0;
    end else begin
      lnk.cmd_rx_en  <= !pd_now; // RL6 RL9
      lnk.odt_buf_en <= !(pd_now && odt_dis); // RL7 RL18
      // Park stays on while the buffer is off, whatever the pin shows
      lnk.park_on    <= (park_cfg != '0) && (!lnk.odt || (pd_now && odt_dis)); // RL8
      lnk.nom_on     <= nom_cfg && lnk.odt && !(odt_dis && pd_now); // RL7
    end
  end

  // Status back to system domain
  logic [3:0] st_s1_q, st_s2_q, st_s3_q;
  always_ff @(posedge clk) begin
    st_s1_q <= {1'b0, st_q};
    st_s2_q <= st_s1_q;
    st_s3_q <= st_s2_q;
  end
  // State word taken only when two samples agree, so a torn word is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_state <= dpd_pkg::DPD_ST_RESET;
      dll_on   <= 1'b1;
      in_pd    <= 1'b0;
    end else if (st_s2_q == st_s3_q) begin
      pd_state <= st_s2_q[2:0];
      dll_on   <= st_s2_q[2:0] != dpd_pkg::DPD_ST_SREF; // RL10
      in_pd    <= st_s2_q[2:0] == dpd_pkg::DPD_ST_PPD || st_s2_q[2:0] == dpd_pkg::DPD_ST_APD;
    end
  end
endmodule // dpd_device

//--- core/dpd_ctrl.sv
module dpd_ctrl (
  // System clock
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Link side
  dpd_link_if.ctl                        lnk,
  // User requests
  input  wire logic                      pd_req,
  input  wire logic                      sref_req,
  input  wire logic                      exit_req,
  input  wire logic                      odt_lvl,
  input  wire logic [dpd_pkg::CNT_W-1:0] tmax_cfg,
  // Status
  output logic                           busy,
  output logic                           cmd_ok
);
  typedef enum logic [2:0] {
    DPD_C_IDLE = 3'h0, DPD_C_ENT = 3'h1, DPD_C_PD = 3'h2,
    DPD_C_EXIT = 3'h3, DPD_C_SR = 3'h4
  } dpd_cst_t;
  dpd_cst_t st_q;
  logic [dpd_pkg::CNT_W-1:0] cnt_q, dur_q;
  logic [3:0] div_q;
  logic       sr_q;

  // Link clock divider
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q  <= 4'h0;
      lnk.ck <= 1'b0;
    end else if (div_q == 4'(dpd_pkg::CK_HALF - 1)) begin
      div_q  <= 4'h0;
      lnk.ck <= !lnk.ck;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  wire ck_fall = (div_q == 4'(dpd_pkg::CK_HALF - 1)) && lnk.ck;

  // Sequencer, updated before each rising link edge
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= DPD_C_IDLE; cnt_q <= '0; dur_q <= '0; sr_q <= 1'b0;
      lnk.reset_n <= 1'b0; lnk.cke <= 1'b1;
      lnk.cmd <= dpd_pkg::DPD_CMD_DES; lnk.odt <= 1'b0; lnk.odt_valid <= 1'b1;
      busy <= 1'b0; cmd_ok <= 1'b0;
    end else if (ck_fall) begin
      lnk.reset_n <= 1'b1;
      lnk.cmd <= dpd_pkg::DPD_CMD_DES; // RL9
      lnk.odt <= odt_lvl; // RL15 RL17
      if (cnt_q != '0) cnt_q <= cnt_q - dpd_pkg::CNT_ONE; // RL21
      case (st_q)
        DPD_C_IDLE: begin
          cmd_ok <= 1'b1;
          if (pd_req || sref_req) begin // RL2
            st_q <= DPD_C_ENT; sr_q <= sref_req;
            cnt_q <= 8'(dpd_pkg::TDODTL_CYC + 1); busy <= 1'b1; cmd_ok <= 1'b0;
          end
        end
        DPD_C_ENT: if (cnt_q == '0) begin
          lnk.cke <= 1'b0; // RL1
          st_q <= sr_q ? DPD_C_SR : DPD_C_PD;
          cnt_q <= 8'(dpd_pkg::TCKE_CYC); dur_q <= tmax_cfg; // RL12 RL16
        end
        DPD_C_PD: begin
          if (dur_q != '0) dur_q <= dur_q - dpd_pkg::CNT_ONE;
          if (cnt_q == '0 && (exit_req || dur_q == '0)) begin // RL13
            lnk.cke <= 1'b1; st_q <= DPD_C_EXIT; // RL14
            cnt_q <= 8'(dpd_pkg::TXP_CYC);
          end
        end
        DPD_C_SR: if (cnt_q == '0 && exit_req) begin
          lnk.cke <= 1'b1; st_q <= DPD_C_EXIT;
          cnt_q <= 8'(dpd_pkg::TMPX_LH_CYC); // RL20
        end
        DPD_C_EXIT: begin
          if (sr_q) lnk.cmd <= dpd_pkg::DPD_CMD_NOP; // RL19
          if (cnt_q == '0) begin st_q <= DPD_C_IDLE; busy <= 1'b0; end
        end
        default: st_q <= DPD_C_IDLE;
      endcase
    end
  end
endmodule // dpd_ctrl

//--- tb/dpd_assertions.sv
module dpd_assertions (
  // Link signals
  input wire logic              ck,
  input wire logic              reset_n,
  input wire logic              cke,
  input wire dpd_pkg::dpd_cmd_t cmd,
  input wire logic              odt,
  input wire logic              odt_valid,
  // Device answers
  input wire logic              cmd_rx_en,
  input wire logic              odt_buf_en,
  input wire logic              park_on,
  input wire logic              nom_on
);
  default clocking cb @(posedge ck); endclocking
  default disable iff (!reset_n);
  // Deselect around clock-enable edges
  ent_des_a: assert property ($fell(cke) |-> (cmd == dpd_pkg::DPD_CMD_DES) [*4])
    else $error("entry without deselect");
  ext_des_a: assert property ($rose(cke) |-> cmd == dpd_pkg::DPD_CMD_DES)
    else $error("exit without deselect");
  // Clock-enable hold times
  low_hold_a: assert property ($fell(cke) |-> (!cke) [*4])
    else $error("clock enable low too short");
  high_hold_a: assert property ($rose(cke) |-> cke [*4])
    else $error("clock enable high too short");
  // Receivers off only after the entry delay
  rx_late_a: assert property ($fell(cmd_rx_en) |-> $past(!cke, 4))
    else $error("receivers off too early");
  rx_back_a: assert property ($rose(cke) |-> ##[0:4] cmd_rx_en)
    else $error("receivers not restored");
  // Termination buffer only off in power-down
  buf_off_a: assert property ($fell(odt_buf_en) |-> !cke)
    else $error("odt buffer off outside power-down");
  nom_off_a: assert property ((!odt_buf_en) [*2] |-> !nom_on)
    else $error("nominal termination with buffer off");
  odt_exit_a: assert property ($rose(cke) |-> odt_valid)
    else $error("odt invalid at exit");
  rst_rx_a: assert property ($rose(reset_n) |-> cmd_rx_en)
    else $error("receivers off after reset");
  // Main scenarios
  pd_c: cover property ($fell(cmd_rx_en));
  buf_c: cover property ($fell(odt_buf_en));
  park_c: cover property (park_on && !cke);
endmodule // dpd_assertions

//--- tb/dram_power_down_control_test.sv
module dram_power_down_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, odt_buf_dis = 0, nom_en = 0, core_busy = 0;
  logic pd_req = 0, exit_req = 0, odt_lvl = 0, dll_on, in_pd, busy, cmd_ok;
  logic sref = 0;
  logic [7:0]  tmax = 8'hC8;
  logic [2:0]  park_sel = 3'h0;
  logic [2:0]  pd_state;
  logic [15:0] bank_open = 16'h0000;
  logic [31:0] rnd = 32'h00000040;
  int          fails = 0, num_checks = 0, cyc = 0;
  int          pats[$];
  dpd_link_if u_dpd_link_if ();
  dpd_device u_dpd_device (.clk(clk), .rst(rst), .lnk(u_dpd_link_if.dev),
    .odt_buf_dis(odt_buf_dis), .park_sel(park_sel), .nom_en(nom_en), .mpx_ok_cfg(1'b0),
    .tcpded_cfg(8'h04), .tmpx_cfg(8'h08), .bank_open(bank_open), .core_busy(core_busy),
    .sref_req(sref), .pd_state(pd_state), .dll_on(dll_on), .in_pd(in_pd));
  dpd_ctrl u_dpd_ctrl (.clk(clk), .rst(rst), .lnk(u_dpd_link_if.ctl), .pd_req(pd_req),
    .sref_req(sref), .exit_req(exit_req), .odt_lvl(odt_lvl), .tmax_cfg(tmax),
    .busy(busy), .cmd_ok(cmd_ok));
  dpd_assertions u_dpd_assertions (.ck(u_dpd_link_if.ck), .reset_n(u_dpd_link_if.reset_n),
    .cke(u_dpd_link_if.cke), .cmd(u_dpd_link_if.cmd), .odt(u_dpd_link_if.odt),
    .odt_valid(u_dpd_link_if.odt_valid), .cmd_rx_en(u_dpd_link_if.cmd_rx_en),
    .odt_buf_en(u_dpd_link_if.odt_buf_en), .park_on(u_dpd_link_if.park_on),
    .nom_on(u_dpd_link_if.nom_on));
  // System clock
  always #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wait_pd(input logic want);
    for (int i = 0; i < 1500 && in_pd !== want; i++) @(negedge clk);
  endtask
  // Enter, compare with the model, optionally leave
  task automatic pd_cycle(input bit do_exit);
    @(negedge clk) pd_req = 1;
    wait_pd(1);
    // Link controls follow the state one link cycle later
    repeat (30) @(negedge clk);
    chk(pd_state, (bank_open == 0) ? dpd_pkg::DPD_ST_PPD : dpd_pkg::DPD_ST_APD, "state");
    chk(in_pd, 1, "entry");
    chk(dll_on, 1, "dll");
    chk(cmd_ok, 0, "no commands");
    chk(u_dpd_link_if.cmd_rx_en, 0, "receivers");
    chk(u_dpd_link_if.odt_buf_en, !odt_buf_dis, "odt buffer");
    if (odt_buf_dis) chk(u_dpd_link_if.nom_on, 0, "nominal");
    else chk(u_dpd_link_if.nom_on, nom_en && odt_lvl, "nominal on");
    chk(u_dpd_link_if.park_on, park_sel != 0 && (!odt_lvl || odt_buf_dis), "park");
    @(negedge clk) pd_req = 0;
    if (do_exit) begin
      exit_req = 1;
      wait_pd(0);
      chk(in_pd, 0, "exit");
      @(negedge clk) exit_req = 0;
      repeat (150) @(negedge clk);
      chk(busy, 0, "idle again");
      chk(cmd_ok, 1, "commands allowed");
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pats = '{0, 1, 2, 3, 4, 5};
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 0;
    repeat (40) @(negedge clk);
    // Random configurations, closed banks first
    while (pats.size() > 0) begin
      rnd = xs(rnd);
      bank_open = (pats.pop_front() == 0) ? 16'h0000 : rnd[15:0];
      park_sel = rnd[18:16];
      odt_lvl = rnd[19];
      odt_buf_dis = rnd[20];
      nom_en = rnd[21];
      pd_cycle(1);
      $display("entry exit test done");
    end
    // Entry held off while the core is busy
    @(negedge clk) core_busy = 1;
    pd_req = 1;
    repeat (150) @(negedge clk);
    chk(in_pd, 0, "busy entry");
    core_busy = 0;
    pd_cycle(1);
    $display("busy test done");
    // Self refresh entered on request, left on the exit request
    @(negedge clk) sref = 1;
    for (int i = 0; i < 1500 && pd_state !== dpd_pkg::DPD_ST_SREF; i++) @(negedge clk);
    chk(pd_state, dpd_pkg::DPD_ST_SREF, "self refresh");
    chk(in_pd, 0, "not power-down");
    @(negedge clk) sref = 0;
    exit_req = 1;
    for (int i = 0; i < 1500 && pd_state !== dpd_pkg::DPD_ST_IDLE; i++) @(negedge clk);
    chk(pd_state, dpd_pkg::DPD_ST_IDLE, "self refresh exit");
    @(negedge clk) exit_req = 0;
    repeat (150) @(negedge clk);
    chk(busy, 0, "nop window over");
    $display("self refresh test done");
    // Duration limit ends power-down with no exit request
    tmax = 8'h20;
    pd_cycle(0);
    wait_pd(0);
    chk(in_pd, 0, "duration limit");
    repeat (150) @(negedge clk);
    tmax = 8'hC8;
    $display("duration test done");
    // Reset inside power-down
    pd_cycle(0);
    rst = 1;
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (40) @(negedge clk);
    chk(in_pd, 0, "reset exit");
    chk(u_dpd_link_if.cmd_rx_en, 1, "reset receivers");
    $display("reset test done");
    summarize();
  end
endmodule // dram_power_down_control_test
